// ---- aosc_core.sv ----
// What this block does
// RQ1 - program mode: hold or go to program value
// RQ2 - program ramp moves toward value at rate
// RQ3 - fault mode: hold or go to fault value
// RQ4 - fault ramp moves toward value at rate
// RQ5 - program-mode link loss: option picks fault
// RQ6 - run-mode link loss always enters fault; here not while inhibited, as inhibit masks link_fall and timeout
// RQ7 - inhibited: no exchange, no fault reports
// RQ8 - controller raises major fault if configured; here major_en is only stored and read back, it drives nothing
// RQ9 - transfer at least once per update interval
// RQ10 - hold output until command matches it
// RQ11 - scaling only in floating point mode
// RQ12 - per-channel sensor offset added to command
// RQ13 - controller shows connection fault type online
// RQ14 - one per-channel ramp rate for all ramps
// RQ15 - no ramp: target taken at next update
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "aosc_params.svh"

module aosc_core
	import aosc_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// register port
	input  wire logic [9:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// controller connection
	input  wire logic        link_up,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_run,
	input  wire logic [63:0] cmd_data,
	output logic             tx_strobe,
	output logic             comm_fault,
	// converter side
	output logic      [63:0] dac_value,
	output logic             dac_update,
	// interrupt
	output logic             irq
);

	localparam logic [4:0] UPDATE_LAST = 5'(`AOSC_UPDATE_CYC - 1);

	aosc_state_s     s;
	aosc_state_s     n;
	logic            tick;
	logic            link_fall;
	logic            timeout;
	logic            cmd_ok;
	logic            comm_loss;
	logic [2:0]      ev;
	logic [2:0]      clr;
	logic [1:0]      ch;
	logic [3:0]      idx;
	logic [3:0][15:0] cmdv;
	logic [3:0][15:0] tgt;
	logic [3:0]      ramp;

	// map command onto signal range between two points
	function automatic logic [15:0] aosc_scale(input logic [15:0] v, input logic [15:0] elo,
		input logic [15:0] ehi, input logic [15:0] slo, input logic [15:0] shi);
		logic signed [16:0] dv;
		logic signed [16:0] de;
		logic signed [16:0] ds;
		logic signed [33:0] num;
		logic signed [33:0] q;
		dv = $signed({v[15], v}) - $signed({elo[15], elo});
		de = $signed({ehi[15], ehi}) - $signed({elo[15], elo});
		ds = $signed({shi[15], shi}) - $signed({slo[15], slo});
		num = dv * ds;
		if (de == 17'sh0) begin
			q = 34'sh0;
		end else begin
			q = num / de;
		end
		return slo + q[15:0];
	endfunction

	// one ramp step, never overshooting the target
	function automatic logic [15:0] aosc_step(input logic [15:0] cur, input logic [15:0] tgt_v,
		input logic [15:0] rate_v);
		logic signed [17:0] diff;
		logic signed [17:0] r;
		diff = $signed({{2{tgt_v[15]}}, tgt_v}) - $signed({{2{cur[15]}}, cur});
		r = $signed({2'b00, rate_v});
		if (rate_v == 16'h0000) begin
			return tgt_v;
		end else if (diff > r) begin
			return cur + rate_v;
		end else if (diff < -r) begin
			return cur - rate_v;
		end else begin
			return tgt_v;
		end
	endfunction

	// event decode from present state
	always_comb begin
		tick      = (s.tick_cnt == UPDATE_LAST);
		cmd_ok    = cmd_valid & link_up & ~s.inhibit;                                   // [RQ7]
		link_fall = s.link_q & ~link_up & ~s.inhibit;                                   // [RQ7]
		timeout   = ~s.inhibit & ~cmd_ok & (s.requested_update_interval != 24'h000000) & (s.rpi_cnt >= s.requested_update_interval); // [RQ9]
		comm_loss = link_fall | timeout;
		ch        = addr[7:6];
		idx       = addr[5:2];
	end

	// next-state logic
	always_comb begin
		n    = s;
		ev   = 3'b000;
		clr  = 3'b000;
		cmdv = '0;
		tgt  = '0;
		ramp = '0;
		if (ce) begin
			n.dac_upd = 1'b0;
			n.tx      = 1'b0;
			n.rdata   = 32'h00000000;
			n.link_q  = link_up;

			// update tick divider, wraps at the last count
			if (tick) begin
				n.tick_cnt = 5'h00;
			end else begin
				n.tick_cnt = s.tick_cnt + 5'h01;
			end

			// latest controller command
			if (cmd_ok) begin
				n.cmd = cmd_data;
			end

			// per-channel target and output update
			for (int i = 0; i < 4; i++) begin
				// commanded value: scaling, then sensor offset
				if (s.float_mode) begin
					cmdv[i] = aosc_scale(s.cmd[i], s.eng_lo[i], s.eng_hi[i],
						s.sig_lo[i], s.sig_hi[i]);                                  // [RQ11]
				end else begin
					cmdv[i] = s.cmd[i];
				end
				cmdv[i] = cmdv[i] + s.offset[i];                                    // [RQ12]

				// target and ramp choice per mode
				case (s.mode)
					AOSC_RUN: begin
						if (s.hold[i] && cmdv[i] != s.out[i]) begin
							tgt[i] = s.out[i];                                      // [RQ10]
						end else begin
							tgt[i] = cmdv[i];
							if (tick) begin
								n.hold[i] = 1'b0;                                   // [RQ10]
							end
						end
						ramp[i] = s.cfg[i][`AOSC_CFG_RRAMP];                         // [RQ14]
					end
					AOSC_PROG: begin
						// user value or hold last
						if (s.cfg[i][`AOSC_CFG_PUSER]) begin
							tgt[i] = s.prog_val[i];                                  // [RQ1]
						end else begin
							tgt[i] = s.out[i];                                       // [RQ1]
						end
						ramp[i] = s.cfg[i][`AOSC_CFG_PRAMP];                         // [RQ2]
					end
					default: begin
						// fault value or hold last
						if (s.cfg[i][`AOSC_CFG_FUSER]) begin
							tgt[i] = s.flt_val[i];                                   // [RQ3]
						end else begin
							tgt[i] = s.out[i];                                       // [RQ3]
						end
						ramp[i] = s.cfg[i][`AOSC_CFG_FRAMP];                         // [RQ4]
					end
				endcase

				// output moves only on the update tick
				if (tick) begin
					if (ramp[i]) begin
						n.out[i] = aosc_step(s.out[i], tgt[i], s.rate[i]);           // [RQ2] [RQ4] [RQ14]
					end else begin
						n.out[i] = tgt[i];                                           // [RQ15]
					end
				end
			end
			if (tick) begin
				n.dac_upd = 1'b1;
			end


			// watchdog and periodic transfer to the controller
			if (s.inhibit || cmd_ok || timeout) begin
				n.rpi_cnt = 24'h000000;
			end else begin
				n.rpi_cnt = s.rpi_cnt + 24'h000001;
			end
			if (s.inhibit) begin
				n.tx_cnt = 24'h000000;                                               // [RQ7]
			end else if (s.tx_cnt + 24'h000001 >= s.requested_update_interval) begin
				n.tx_cnt = 24'h000000;
				n.tx     = 1'b1;                                                     // [RQ9]
			end else begin
				n.tx_cnt = s.tx_cnt + 24'h000001;
			end


			// mode sequencing
			if (cmd_ok) begin
				n.mode = cmd_run ? AOSC_RUN : AOSC_PROG;
				if (cmd_run && s.mode != AOSC_RUN) begin
					for (int i = 0; i < 4; i++) begin
						n.hold[i] = s.cfg[i][`AOSC_CFG_HOLD];                       // [RQ10]
					end
				end
			end else if (comm_loss) begin
				// record the cause, link drop first
				if (link_fall) begin
					n.fault_type = `AOSC_FT_LINK;
				end else begin
					n.fault_type = `AOSC_FT_TIMEOUT;
				end
				// run always faults, program only by option
				if (s.mode == AOSC_RUN) begin
					n.mode = AOSC_FAULT;                                             // [RQ6]
				end else if (s.mode == AOSC_PROG && s.prog_loss_fault) begin
					n.mode = AOSC_FAULT;                                             // [RQ5]
				end
			end

			// inhibited: no fault cause reported
			if (s.inhibit) begin
				n.fault_type = `AOSC_FT_NONE;                                        // [RQ7]
			end
			n.fault_out = (n.mode == AOSC_FAULT);


			// events
			ev[`AOSC_ST_LINK]    = link_fall;
			ev[`AOSC_ST_TIMEOUT] = timeout;
			ev[`AOSC_ST_FAULT]   = (n.mode == AOSC_FAULT) && (s.mode != AOSC_FAULT);


			// register writes, global registers first
			if (wr) begin
				if (addr == `AOSC_ADDR_CTRL) begin
					n.inhibit         = wdata[`AOSC_CTRL_INHIBIT];
					n.float_mode      = wdata[`AOSC_CTRL_FLOAT];
					n.prog_loss_fault = wdata[`AOSC_CTRL_PLOSS];
					n.major_en        = wdata[`AOSC_CTRL_MAJOR];
				end else if (addr == `AOSC_ADDR_STATUS) begin
					clr = wdata[2:0];
				end else if (addr == `AOSC_ADDR_MASK) begin
					n.mask = wdata[2:0];
				end else if (addr == `AOSC_ADDR_RPI) begin
					n.requested_update_interval = wdata[23:0];
				end else if (addr[9:8] == `AOSC_CH_SEL) begin
					// per-channel window, unmapped indexes ignored
					if (idx == `AOSC_CH_CFG) begin
						n.cfg[ch] = wdata[5:0];
					end else if (idx == `AOSC_CH_PROG) begin
						n.prog_val[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_FLT) begin
						n.flt_val[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_RATE) begin
						n.rate[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_OFFS) begin
						n.offset[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_SIG_LO) begin
						n.sig_lo[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_SIG_HI) begin
						n.sig_hi[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_ENG_LO) begin
						n.eng_lo[ch] = wdata[15:0];
					end else if (idx == `AOSC_CH_ENG_HI) begin
						n.eng_hi[ch] = wdata[15:0];
					end
				end
			end


			// sticky status: a new event beats the clear
			n.status = (s.status & ~clr) | ev;
			n.irq    = |(n.status & n.mask);


			// register reads, data valid the next cycle only
			if (rd) begin
				if (addr == `AOSC_ADDR_CTRL) begin
					n.rdata = {28'h0000000, s.major_en, s.prog_loss_fault, s.float_mode, s.inhibit};
				end else if (addr == `AOSC_ADDR_STATUS) begin
					n.rdata = {29'h00000000, s.status};
				end else if (addr == `AOSC_ADDR_MASK) begin
					n.rdata = {29'h00000000, s.mask};
				end else if (addr == `AOSC_ADDR_STATE) begin
					n.rdata = {24'h000000, s.fault_type, s.hold, s.mode};
				end else if (addr == `AOSC_ADDR_RPI) begin
					n.rdata = {8'h00, s.requested_update_interval};
				end else if (addr[9:8] == `AOSC_CH_SEL) begin
					// per-channel window, unmapped indexes read zero
					if (idx == `AOSC_CH_CFG) begin
						n.rdata = {26'h0000000, s.cfg[ch]};
					end else if (idx == `AOSC_CH_PROG) begin
						n.rdata = {16'h0000, s.prog_val[ch]};
					end else if (idx == `AOSC_CH_FLT) begin
						n.rdata = {16'h0000, s.flt_val[ch]};
					end else if (idx == `AOSC_CH_RATE) begin
						n.rdata = {16'h0000, s.rate[ch]};
					end else if (idx == `AOSC_CH_OFFS) begin
						n.rdata = {16'h0000, s.offset[ch]};
					end else if (idx == `AOSC_CH_SIG_LO) begin
						n.rdata = {16'h0000, s.sig_lo[ch]};
					end else if (idx == `AOSC_CH_SIG_HI) begin
						n.rdata = {16'h0000, s.sig_hi[ch]};
					end else if (idx == `AOSC_CH_ENG_LO) begin
						n.rdata = {16'h0000, s.eng_lo[ch]};
					end else if (idx == `AOSC_CH_ENG_HI) begin
						n.rdata = {16'h0000, s.eng_hi[ch]};
					end else if (idx == `AOSC_CH_OUT) begin
						n.rdata = {16'h0000, s.out[ch]};
					end
				end
			end
		end
	end

	// state register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s      <= '0;
			s.mode <= AOSC_PROG;   // outputs idle until first command
			s.requested_update_interval  <= `AOSC_RPI_RST;
		end else begin
			s <= n;
		end
	end

	// outputs straight from state
	assign rdata      = s.rdata;
	assign tx_strobe  = s.tx;
	assign comm_fault = s.fault_out;
	assign dac_value  = s.out;
	assign dac_update = s.dac_upd;
	assign irq        = s.irq;

endmodule
`default_nettype wire

// ---- aosc_params.svh ----
`ifndef AOSC_PARAMS_SVH
`define AOSC_PARAMS_SVH

// timing
`define AOSC_CLK_NS       40
`define AOSC_UPDATE_NS    1000
`define AOSC_UPDATE_CYC   ((`AOSC_UPDATE_NS + `AOSC_CLK_NS - 1) / `AOSC_CLK_NS)
`define AOSC_RPI_RST      24'h00C350

// global register byte addresses
`define AOSC_ADDR_CTRL    10'h000
`define AOSC_ADDR_STATUS  10'h004
`define AOSC_ADDR_MASK    10'h008
`define AOSC_ADDR_STATE   10'h00C
`define AOSC_ADDR_RPI     10'h010
// channel window: 10'h100 + channel * 10'h040 + index * 4
`define AOSC_CH_SEL       2'h1
`define AOSC_CH_CFG       4'h0
`define AOSC_CH_PROG      4'h1
`define AOSC_CH_FLT       4'h2
`define AOSC_CH_RATE      4'h3
`define AOSC_CH_OFFS      4'h4
`define AOSC_CH_SIG_LO    4'h5
`define AOSC_CH_SIG_HI    4'h6
`define AOSC_CH_ENG_LO    4'h7
`define AOSC_CH_ENG_HI    4'h8
`define AOSC_CH_OUT       4'h9

// control register fields
`define AOSC_CTRL_INHIBIT 0
`define AOSC_CTRL_FLOAT   1
`define AOSC_CTRL_PLOSS   2
`define AOSC_CTRL_MAJOR   3

// channel configuration fields
`define AOSC_CFG_PUSER    0
`define AOSC_CFG_PRAMP    1
`define AOSC_CFG_FUSER    2
`define AOSC_CFG_FRAMP    3
`define AOSC_CFG_HOLD     4
`define AOSC_CFG_RRAMP    5

// status / mask fields
`define AOSC_ST_LINK      0
`define AOSC_ST_TIMEOUT   1
`define AOSC_ST_FAULT     2

// connection fault type codes
`define AOSC_FT_NONE      2'h0
`define AOSC_FT_LINK      2'h1
`define AOSC_FT_TIMEOUT   2'h2

`endif

// ---- aosc_pkg.sv ----
package aosc_pkg;

	typedef enum logic [1:0] {
		AOSC_RUN   = 2'b00,
		AOSC_PROG  = 2'b01,
		AOSC_FAULT = 2'b10
	} aosc_mode_e;

	typedef struct packed {
		aosc_mode_e        mode;
		logic              inhibit;
		logic              float_mode;
		logic              prog_loss_fault;
		logic              major_en;
		logic [2:0]        status;
		logic [2:0]        mask;
		logic [1:0]        fault_type;
		logic [23:0]       requested_update_interval;
		logic [23:0]       rpi_cnt;
		logic [23:0]       tx_cnt;
		logic [4:0]        tick_cnt;
		logic              link_q;
		logic [3:0]        hold;
		logic [3:0][5:0]   cfg;
		logic [3:0][15:0]  prog_val;
		logic [3:0][15:0]  flt_val;
		logic [3:0][15:0]  rate;
		logic [3:0][15:0]  offset;
		logic [3:0][15:0]  sig_lo;
		logic [3:0][15:0]  sig_hi;
		logic [3:0][15:0]  eng_lo;
		logic [3:0][15:0]  eng_hi;
		logic [3:0][15:0]  cmd;
		logic [3:0][15:0]  out;
		logic              dac_upd;
		logic              tx;
		logic              irq;
		logic              fault_out;
		logic [31:0]       rdata;
	} aosc_state_s;

endpackage

// ---- aosc_core_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module aosc_core_monitor (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// watched ports
	input wire logic        wr,
	input wire logic        link_up,
	input wire logic        cmd_valid,
	input wire logic        cmd_run,
	input wire logic        tx_strobe,
	input wire logic        comm_fault,
	input wire logic [63:0] dac_value,
	input wire logic        dac_update,
	input wire logic        irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic run_q;
	// run mode as seen from accepted commands
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			run_q <= 1'b0;
		else if (!link_up)
			run_q <= 1'b0;
		else if (cmd_valid)
			run_q <= cmd_run;
	end
	// output update and transfer timing
	a_upd_single: assert property (dac_update |=> !dac_update) else $error("update pulse too long");
	a_upd_period: assert property (dac_update |-> ##25 dac_update) else $error("update period wrong");
	a_out_on_tick: assert property ($changed(dac_value) |-> dac_update) else $error("output moved off tick");
	a_tx_gap: assert property (tx_strobe |=> !tx_strobe [*3]) else $error("transfer pulses too close");
	// fault mode entry and exit
	a_run_loss: assert property (run_q && $fell(link_up) |-> ##[0:2] comm_fault) else $error("no fault");
	a_fault_stays: assert property (comm_fault && !cmd_valid && !wr && !$past(wr) |=> comm_fault)
		else $error("fault mode left alone");
	a_cmd_exit: assert property (comm_fault && cmd_valid && link_up |-> ##[1:2] !comm_fault)
		else $error("command did not end fault");
	a_reset_quiet: assert property ($rose(rst_b) |-> !comm_fault && !irq && dac_value == 64'h0)
		else $error("outputs not quiet after reset");
	// main scenarios
	c_fault_tick: cover property (dac_update && comm_fault);
	c_link_drop: cover property ($fell(link_up));
	c_tx: cover property (tx_strobe);
endmodule

bind aosc_core aosc_core_monitor aosc_core_monitor_inst (.clock(clock), .rst_b(rst_b), .wr(wr), .link_up(link_up),
	.cmd_valid(cmd_valid), .cmd_run(cmd_run), .tx_strobe(tx_strobe), .comm_fault(comm_fault),
	.dac_value(dac_value), .dac_update(dac_update), .irq(irq));
`default_nettype wire

// ---- aosc_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module aosc_ctrl_model (
	// clock
	input  wire logic        clock,
	// connection to the block
	output logic             link_up,
	output logic             cmd_valid,
	output logic             cmd_run,
	output logic      [63:0] cmd_data
);
	// idle at time zero
	initial begin
		link_up = 1'b1;
		cmd_valid = 1'b0;
		cmd_run = 1'b0;
		cmd_data = 64'h0;
	end
	// one command, data scrambled once released
	task automatic send(input logic run, input logic [63:0] d);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_run <= run;
		cmd_data <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
		cmd_run <= ~run;
		cmd_data <= ~d;
	endtask
	// connection present or lost
	task automatic link(input logic v);
		@(posedge clock);
		link_up <= v;
	endtask
endmodule
`default_nettype wire

// ---- test_aosc_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "aosc_params.svh"
module test_aosc_core;
	logic        clock, rst_b, wr, rd, link_up, cmd_valid, cmd_run, tx_strobe, comm_fault, dac_update, irq;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata, v0, v1;
	logic [63:0] cmd_data, dac_value;
	int          num_errors, n_tests, k;
	// block and controller model
	aosc_core aosc_core_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link_up(link_up), .cmd_valid(cmd_valid), .cmd_run(cmd_run), .cmd_data(cmd_data),
		.tx_strobe(tx_strobe), .comm_fault(comm_fault), .dac_value(dac_value), .dac_update(dac_update), .irq(irq));
	aosc_ctrl_model aosc_ctrl_model_inst (.clock(clock), .link_up(link_up), .cmd_valid(cmd_valid),
		.cmd_run(cmd_run), .cmd_data(cmd_data));
	// verdict and end of run
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// register port cycles
	task automatic wreg(input logic [9:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [31:0] e);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	function automatic logic [9:0] ca(input logic [1:0] c, input logic [3:0] i);
		return 10'h100 + {2'h0, c, 6'h00} + {4'h0, i, 2'b00};
	endfunction
	function automatic logic [31:0] ch(input int n);
		return {16'h0, dac_value[16*n +: 16]};
	endfunction
	// bounded waits
	task automatic wait_upd;
		for (k = 0; k < 60 && dac_update !== 1'b1; k++)
			@(negedge clock);
		if (k == 60) begin
			num_errors++;
			tally_and_finish();
		end
		@(negedge clock);
		for (k = 0; k < 60 && dac_update !== 1'b1; k++)
			@(negedge clock);
		if (k == 60) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic count_tx(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clock);
			if (tx_strobe === 1'b1)
				c++;
		end
	endtask
	// scenarios
	task automatic t_reset;
		rchk(`AOSC_ADDR_STATE, 32'h1);
		rchk(`AOSC_ADDR_RPI, 32'h00C350);
		rchk(10'h3FC, 32'h0);
	endtask
	task automatic t_prog;
		wreg(ca(0, `AOSC_CH_CFG), 32'h1);
		wreg(ca(0, `AOSC_CH_PROG), 32'h0123);
		aosc_ctrl_model_inst.send(1'b0, 64'h0);
		wait_upd();
		wait_upd();
		chk(ch(0), 32'h0123);
		chk(ch(1), 32'h0);
	endtask
	task automatic t_run;
		wreg(ca(1, `AOSC_CH_OFFS), 32'h5);
		wreg(ca(2, `AOSC_CH_CFG), 32'h10);
		aosc_ctrl_model_inst.send(1'b1, 64'h0000_0050_0010_0200);
		wait_upd();
		wait_upd();
		chk(ch(0), 32'h0200);
		chk(ch(1), 32'h0015);
		chk(ch(2), 32'h0);
		aosc_ctrl_model_inst.send(1'b1, 64'h0000_0000_0010_0200);
		wait_upd();
		aosc_ctrl_model_inst.send(1'b1, 64'h0000_0030_0010_0200);
		wait_upd();
		wait_upd();
		chk(ch(2), 32'h0030);
	endtask
	task automatic t_drop;
		wreg(ca(0, `AOSC_CH_CFG), 32'hC);
		wreg(ca(0, `AOSC_CH_FLT), 32'h0400);
		wreg(ca(0, `AOSC_CH_RATE), 32'h10);
		wreg(`AOSC_ADDR_MASK, 32'h7);
		aosc_ctrl_model_inst.link(1'b0);
		repeat (3) @(negedge clock);
		chk({30'h0, comm_fault, irq}, 32'h3);
		rchk(`AOSC_ADDR_STATUS, 32'h5);
		rchk(`AOSC_ADDR_STATE, 32'h42);
		wait_upd();
		v0 = ch(0);
		wait_upd();
		v1 = ch(0);
		chk(v1 - v0, 32'h10);
		wreg(`AOSC_ADDR_STATUS, 32'h7);
		repeat (2) @(negedge clock);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_prog_loss;
		aosc_ctrl_model_inst.link(1'b1);
		aosc_ctrl_model_inst.send(1'b0, 64'h0);
		wreg(`AOSC_ADDR_RPI, 32'd20);
		count_tx(50, k);
		chk({31'h0, comm_fault}, 32'h0);
		chk(k >= 2, 32'h1);
		wreg(`AOSC_ADDR_CTRL, 32'h4);
		repeat (30) @(negedge clock);
		chk({31'h0, comm_fault}, 32'h1);
		rchk(`AOSC_ADDR_STATE, 32'h82);
		wreg(`AOSC_ADDR_CTRL, 32'h1);
		repeat (2) @(negedge clock);
		count_tx(50, k);
		chk(k, 32'h0);
		rchk(`AOSC_ADDR_STATE, 32'h02);
	endtask
	task automatic t_scale;
		wreg(`AOSC_ADDR_RPI, 32'h1000);
		wreg(`AOSC_ADDR_CTRL, 32'hA);
		rchk(`AOSC_ADDR_CTRL, 32'hA);
		wreg(ca(3, `AOSC_CH_ENG_HI), 32'h64);
		wreg(ca(3, `AOSC_CH_SIG_HI), 32'hC8);
		aosc_ctrl_model_inst.send(1'b1, 64'h000A_0000_0000_0000);
		wait_upd();
		wait_upd();
		chk({31'h0, comm_fault}, 32'h0);
		chk(ch(3), 32'h0014);
	endtask
	// clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 10'h0;
		wdata = 32'h0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_prog();
		t_run();
		t_drop();
		t_prog_loss();
		t_scale();
		tally_and_finish();
	end
endmodule
`default_nettype wire
